// ### design/dus_sequencer.v
// Behaviour
// - fan locked too long flags fan failure
// - repick forward feeds, reverse moves guide
// - adjust command reverses repick motor
// - forward command runs reverse motor forward
// - reverse command runs reverse motor backward
// - repick forward after delay from reversal
// - stop reverse motor after run period
// - stop repick after leading edge delay
// - repick command feeds page forward
// - stop repick after trailing edge delay
// - five guide positions, cyclic from home
// - adjust seeks home, steps, then stops
// - no home in two cam turns: guide fail
// - any jam halts and reports
// - no leading edge in window: reverse jam
// - no trailing edge in window: stationary jam
`timescale 1ns/1ns
`include "dus_regs.vh"
module dus_sequencer #(
    parameter [31:0] FAN_LOCK_CYC = `DUS_FAN_LOCK_CYC,
    parameter [31:0] REV_TO_REPICK_CYC = `DUS_REV_TO_REPICK_CYC,
    parameter [31:0] REV_RUN_CYC = `DUS_REV_RUN_CYC,
    parameter [31:0] LEAD_STOP_CYC = `DUS_LEAD_STOP_CYC,
    parameter [31:0] TRAIL_STOP_CYC = `DUS_TRAIL_STOP_CYC,
    parameter [31:0] REV_JAM_CYC = `DUS_REV_JAM_CYC,
    parameter [31:0] STAT_JAM_CYC = `DUS_STAT_JAM_CYC,
    parameter [31:0] CAM_TURN_CYC = `DUS_CAM_TURN_CYC,
    parameter [31:0] GUIDE_STEP_CYC = `DUS_GUIDE_STEP_CYC
) (
    input wire clk,
    input wire rst,
    input wire cmd_fwd,
    input wire cmd_rev,
    input wire cmd_repick,
    input wire cmd_adjust,
    input wire [2:0] cmd_size,
    input wire cmd_clear,
    input wire fan_locked,
    input wire repick_media_sensor,
    input wire guide_home_sensor,
    input wire face_up_sensor,
    output reg cooling_fan_on,
    output reg reverse_motor_run,
    output reg reverse_motor_dir,
    output reg repick_motor_run,
    output reg repick_motor_dir,
    output reg fan_fail,
    output reg guide_fail,
    output reg jam_reverse_delay,
    output reg jam_stationary,
    output reg busy,
    output reg face_up_open,
    output reg [2:0] guide_pos
);
    localparam [2:0] RS_IDLE = 3'h0;
    localparam [2:0] RS_FWD = 3'h1;
    localparam [2:0] RS_REV = 3'h2;
    localparam [2:0] RS_STOP = 3'h3;
    localparam [2:0] PS_IDLE = 3'h0;
    localparam [2:0] PS_WAIT = 3'h1;
    localparam [2:0] PS_ALIGN = 3'h2;
    localparam [2:0] PS_LSTOP = 3'h3;
    localparam [2:0] PS_FEED = 3'h4;
    localparam [2:0] PS_TSTOP = 3'h5;
    localparam [2:0] PS_HOME = 3'h6;
    localparam [2:0] PS_STEP = 3'h7;

    // three-stage sync; second and third must agree before a change counts
    reg [2:0] sy1_r, sy2_r, sy3_r, sen_r;
    wire [2:0] raw = {face_up_sensor, guide_home_sensor, repick_media_sensor};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge clk) begin
                if (rst) begin
                    sy1_r[gi] <= 1'h0;
                    sy2_r[gi] <= 1'h0;
                    sy3_r[gi] <= 1'h0;
                    sen_r[gi] <= 1'h0;
                end else begin
                    sy1_r[gi] <= raw[gi];
                    sy2_r[gi] <= sy1_r[gi];
                    sy3_r[gi] <= sy2_r[gi];
                    if (sy2_r[gi] == sy3_r[gi])
                        sen_r[gi] <= sy3_r[gi];
                end
            end
        end
    endgenerate
    reg fl1_r, fl2_r, fl3_r, fan_lk_r;
    always @(posedge clk) begin
        if (rst) begin
            fl1_r <= 1'h0;
            fl2_r <= 1'h0;
            fl3_r <= 1'h0;
            fan_lk_r <= 1'h0;
        end else begin
            fl1_r <= fan_locked;
            fl2_r <= fl1_r;
            fl3_r <= fl2_r;
            if (fl2_r == fl3_r)
                fan_lk_r <= fl3_r;
        end
    end

    wire media = sen_r[0];
    wire home = sen_r[1];
    reg media_d_r;
    wire lead_edge = media & ~media_d_r;
    wire trail_edge = ~media & media_d_r;

    // maps a size code onto the five guide positions; any code past A5 selects the home (letter) position
    function [2:0] dus_wrap;
        input [2:0] p;
        begin
            dus_wrap = (p >= `DUS_POS_COUNT) ? `DUS_POS_LETTER : p;
        end
    endfunction

    reg [2:0] rs_r, ps_r;
    reg [31:0] rcnt_r, pcnt_r, fcnt_r, jcnt_r;
    reg [2:0] target_r;
    reg rjam_arm_r, sjam_arm_r;
    wire jam_any = jam_reverse_delay | jam_stationary;
    wire halt = jam_any | guide_fail;

    // fan runs whenever out of reset, jam or not; lock watchdog counts while locked
    always @(posedge clk) begin
        if (rst) begin
            cooling_fan_on <= 1'h0;
            fcnt_r <= 32'h0;
            fan_fail <= 1'h0;
            face_up_open <= 1'h0;
        end else begin
            cooling_fan_on <= 1'h1;
            face_up_open <= sen_r[2];
            if (!cooling_fan_on || !fan_lk_r)
                fcnt_r <= 32'h0;
            else if (fcnt_r < FAN_LOCK_CYC)
                fcnt_r <= fcnt_r + 32'h1;
            if (cooling_fan_on && fan_lk_r && fcnt_r + 32'h1 >= FAN_LOCK_CYC)
                fan_fail <= 1'h1;
            else if (cmd_clear)
                fan_fail <= 1'h0;
        end
    end

    // reverse motor sequencer
    always @(posedge clk) begin
        if (rst) begin
            rs_r <= RS_IDLE;
            rcnt_r <= 32'h0;
            reverse_motor_run <= 1'h0;
            reverse_motor_dir <= `DUS_DIR_FWD;
        end else if (halt) begin
            rs_r <= RS_IDLE;
            reverse_motor_run <= 1'h0;
        end else begin
            case (rs_r)
                RS_IDLE, RS_FWD: begin
                    if (cmd_rev) begin
                        rs_r <= RS_REV;
                        rcnt_r <= 32'h0;
                        reverse_motor_run <= 1'h1;
                        reverse_motor_dir <= `DUS_DIR_REV;
                    end else if (cmd_fwd) begin
                        rs_r <= RS_FWD;
                        reverse_motor_run <= 1'h1;
                        reverse_motor_dir <= `DUS_DIR_FWD;
                    end
                end
                RS_REV: begin
                    rcnt_r <= rcnt_r + 32'h1;
                    if (rcnt_r + 32'h1 >= REV_RUN_CYC) begin
                        rs_r <= RS_STOP;
                        reverse_motor_run <= 1'h0;
                    end
                end
                RS_STOP: rs_r <= RS_IDLE;
                default: rs_r <= RS_IDLE;
            endcase
        end
    end
    wire rev_start = !halt && (rs_r == RS_IDLE || rs_r == RS_FWD) && cmd_rev;

    // re-pickup motor and guide sequencer
    always @(posedge clk) begin
        if (rst) begin
            ps_r <= PS_IDLE;
            pcnt_r <= 32'h0;
            repick_motor_run <= 1'h0;
            repick_motor_dir <= `DUS_DIR_FWD;
            guide_pos <= `DUS_POS_LETTER;
            target_r <= `DUS_POS_LETTER;
            guide_fail <= 1'h0;
            busy <= 1'h0;
            media_d_r <= 1'h0;
        end else begin
            media_d_r <= media;
            if (cmd_clear && ps_r == PS_IDLE)
                guide_fail <= 1'h0;
            if (halt && ps_r != PS_IDLE) begin
                ps_r <= PS_IDLE;
                repick_motor_run <= 1'h0;
                busy <= 1'h0;
            end else begin
                case (ps_r)
                    PS_IDLE: begin
                        if (rev_start) begin
                            ps_r <= PS_WAIT;
                            pcnt_r <= 32'h0;
                            busy <= 1'h1;
                        end else if (cmd_repick && !halt) begin
                            ps_r <= PS_FEED;
                            repick_motor_run <= 1'h1;
                            repick_motor_dir <= `DUS_DIR_FWD;
                            busy <= 1'h1;
                        end else if (cmd_adjust && !halt) begin
                            ps_r <= PS_HOME;
                            pcnt_r <= 32'h0;
                            target_r <= dus_wrap(cmd_size);
                            repick_motor_run <= 1'h1;
                            repick_motor_dir <= `DUS_DIR_REV;
                            busy <= 1'h1;
                        end
                    end
                    PS_WAIT: begin
                        pcnt_r <= pcnt_r + 32'h1;
                        if (pcnt_r + 32'h1 >= REV_TO_REPICK_CYC) begin
                            ps_r <= PS_ALIGN;
                            repick_motor_run <= 1'h1;
                            repick_motor_dir <= `DUS_DIR_FWD;
                        end
                    end
                    PS_ALIGN: begin
                        if (lead_edge) begin
                            ps_r <= PS_LSTOP;
                            pcnt_r <= 32'h0;
                        end
                    end
                    PS_LSTOP: begin
                        pcnt_r <= pcnt_r + 32'h1;
                        if (pcnt_r + 32'h1 >= LEAD_STOP_CYC) begin
                            ps_r <= PS_IDLE;
                            repick_motor_run <= 1'h0;
                            busy <= 1'h0;
                        end
                    end
                    PS_FEED: begin
                        if (trail_edge) begin
                            ps_r <= PS_TSTOP;
                            pcnt_r <= 32'h0;
                        end
                    end
                    PS_TSTOP: begin
                        pcnt_r <= pcnt_r + 32'h1;
                        if (pcnt_r + 32'h1 >= TRAIL_STOP_CYC) begin
                            ps_r <= PS_IDLE;
                            repick_motor_run <= 1'h0;
                            busy <= 1'h0;
                        end
                    end
                    PS_HOME: begin
                        pcnt_r <= pcnt_r + 32'h1;
                        if (home) begin
                            ps_r <= PS_STEP;
                            guide_pos <= `DUS_POS_LETTER;
                            pcnt_r <= 32'h0;
                        end else if (pcnt_r + 32'h1 >= {CAM_TURN_CYC[30:0], 1'h0}) begin
                            guide_fail <= 1'h1;
                            repick_motor_run <= 1'h0;
                            ps_r <= PS_IDLE;
                            busy <= 1'h0;
                        end
                    end
                    PS_STEP: begin
                        if (guide_pos == target_r) begin
                            ps_r <= PS_IDLE;
                            repick_motor_run <= 1'h0;
                            busy <= 1'h0;
                        end else if (pcnt_r + 32'h1 >= GUIDE_STEP_CYC) begin
                            pcnt_r <= 32'h0;
                            guide_pos <= (guide_pos == `DUS_POS_A5) ? `DUS_POS_LETTER
                                : guide_pos + 3'h1;
                        end else begin
                            pcnt_r <= pcnt_r + 32'h1;
                        end
                    end
                    default: ps_r <= PS_IDLE;
                endcase
            end
        end
    end

    // jam windows; set wins over clear; controller handles fallback itself
    always @(posedge clk) begin
        if (rst) begin
            jcnt_r <= 32'h0;
            rjam_arm_r <= 1'h0;
            sjam_arm_r <= 1'h0;
            jam_reverse_delay <= 1'h0;
            jam_stationary <= 1'h0;
        end else begin
            if (rev_start) begin
                rjam_arm_r <= 1'h1;
                sjam_arm_r <= 1'h0;
                jcnt_r <= 32'h0;
            end else if (ps_r == PS_IDLE && cmd_repick && !halt) begin
                sjam_arm_r <= 1'h1;
                rjam_arm_r <= 1'h0;
                jcnt_r <= 32'h0;
            end else if (rjam_arm_r || sjam_arm_r) begin
                jcnt_r <= jcnt_r + 32'h1;
            end
            if (rjam_arm_r && lead_edge)
                rjam_arm_r <= 1'h0;
            if (sjam_arm_r && trail_edge)
                sjam_arm_r <= 1'h0;
            if (rjam_arm_r && !lead_edge && jcnt_r + 32'h1 >= REV_JAM_CYC) begin
                jam_reverse_delay <= 1'h1;
                rjam_arm_r <= 1'h0;
            end else if (cmd_clear)
                jam_reverse_delay <= 1'h0;
            if (sjam_arm_r && !trail_edge && jcnt_r + 32'h1 >= STAT_JAM_CYC) begin
                jam_stationary <= 1'h1;
                sjam_arm_r <= 1'h0;
            end else if (cmd_clear)
                jam_stationary <= 1'h0;
        end
    end
endmodule

// ### design/dus_regs.vh
`ifndef DUS_REGS_VH
`define DUS_REGS_VH
// timing figures in nanoseconds; cycle counts derive from the 10 ns clock
`define DUS_CLK_NS 10
`define DUS_FAN_LOCK_NS 500000000
`define DUS_REV_TO_REPICK_NS 200000000
`define DUS_REV_RUN_NS 800000000
`define DUS_LEAD_STOP_NS 50000000
`define DUS_TRAIL_STOP_NS 50000000
`define DUS_REV_JAM_NS 1500000000
`define DUS_STAT_JAM_NS 2000000000
`define DUS_CAM_TURN_NS 300000000
`define DUS_GUIDE_STEP_NS 60000000
// longest times round down, least times round up
`define DUS_FAN_LOCK_CYC (`DUS_FAN_LOCK_NS / `DUS_CLK_NS)
`define DUS_REV_TO_REPICK_CYC ((`DUS_REV_TO_REPICK_NS + `DUS_CLK_NS - 1) / `DUS_CLK_NS)
`define DUS_REV_RUN_CYC (`DUS_REV_RUN_NS / `DUS_CLK_NS)
`define DUS_LEAD_STOP_CYC (`DUS_LEAD_STOP_NS / `DUS_CLK_NS)
`define DUS_TRAIL_STOP_CYC (`DUS_TRAIL_STOP_NS / `DUS_CLK_NS)
`define DUS_REV_JAM_CYC (`DUS_REV_JAM_NS / `DUS_CLK_NS)
`define DUS_STAT_JAM_CYC (`DUS_STAT_JAM_NS / `DUS_CLK_NS)
`define DUS_CAM_TURN_CYC (`DUS_CAM_TURN_NS / `DUS_CLK_NS)
`define DUS_GUIDE_STEP_CYC (`DUS_GUIDE_STEP_NS / `DUS_CLK_NS)
// guide positions, home first
`define DUS_POS_COUNT 5
`define DUS_POS_LETTER 3'h0
`define DUS_POS_A5 3'h4
// motor direction encoding
`define DUS_DIR_FWD 1'h0
`define DUS_DIR_REV 1'h1
`endif

// ### sim/dus_ctrl_model.sv
`timescale 1ns/1ns
// main engine controller: turns delivery edges and bench requests into duplex commands
module dus_ctrl_model #(
    parameter int LEAD_DLY = 6,
    parameter int TRAIL_DLY = 6
) (
    input wire clk,
    input wire rst,
    input wire delivery_sensor,
    input wire req_repick,
    input wire req_adjust,
    input wire [2:0] req_size,
    input wire fault,
    input wire clr,
    output logic cmd_fwd,
    output logic cmd_rev,
    output wire cmd_repick,
    output wire cmd_adjust,
    output wire [2:0] cmd_size,
    output logic simplex
);
    initial cmd_fwd = 1'b0;
    initial cmd_rev = 1'b0;
    // once a fault is seen the sheet goes out simplex, so no further duplex commands
    assign cmd_repick = req_repick & ~simplex;
    assign cmd_adjust = req_adjust & ~simplex;
    assign cmd_size = req_size;
    always @(posedge clk) simplex <= (rst | clr) ? 1'b0 : (simplex | fault);
    // one-cycle forward pulse a fixed delay after the leading edge
    always @(posedge delivery_sensor) if (!simplex) begin
        repeat (LEAD_DLY) @(posedge clk);
        #1 cmd_fwd = 1'b1;
        @(posedge clk);
        #1 cmd_fwd = 1'b0;
    end
    // one-cycle reverse pulse a fixed delay after the trailing edge
    always @(negedge delivery_sensor) if (!simplex) begin
        repeat (TRAIL_DLY) @(posedge clk);
        #1 cmd_rev = 1'b1;
        @(posedge clk);
        #1 cmd_rev = 1'b0;
    end
endmodule

// ### sim/dus_sequencer_asserts.sv
`timescale 1ns/1ns
module dus_sequencer_chk #(
    parameter [31:0] FAN_LOCK_CYC = 20,
    parameter [31:0] REV_TO_REPICK_CYC = 5,
    parameter [31:0] REV_RUN_CYC = 12,
    parameter [31:0] REV_JAM_CYC = 40,
    parameter [31:0] STAT_JAM_CYC = 40
) (
    input wire clk,
    input wire rst,
    input wire cmd_fwd,
    input wire cmd_rev,
    input wire cmd_repick,
    input wire cmd_adjust,
    input wire [2:0] cmd_size,
    input wire fan_locked,
    input wire reverse_motor_run,
    input wire reverse_motor_dir,
    input wire repick_motor_run,
    input wire repick_motor_dir,
    input wire fan_fail,
    input wire guide_fail,
    input wire jam_reverse_delay,
    input wire jam_stationary,
    input wire busy,
    input wire [2:0] guide_pos
);
    localparam int P0 = REV_TO_REPICK_CYC;
    localparam int P1 = REV_TO_REPICK_CYC + 1;
    localparam int S0 = REV_RUN_CYC;
    localparam int S1 = REV_RUN_CYC + 1;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire hlt = jam_reverse_delay | jam_stationary | guide_fail;
    wire ok = ~(hlt | fan_fail);
    wire rv = reverse_motor_run & reverse_motor_dir;
    int rc_r, sc_r, fc_r;
    logic [2:0] tgt_r;
    // cycles since each cause; saturating so long idle spells never wrap
    always @(posedge clk) begin
        if (rst) begin
            rc_r <= 0;
            sc_r <= 0;
            fc_r <= 0;
            tgt_r <= 3'h0;
        end else begin
            rc_r <= cmd_rev ? 1 : (rc_r != 0 && rc_r < 5000) ? rc_r + 1 : rc_r;
            sc_r <= cmd_repick ? 1 : (sc_r != 0 && sc_r < 5000) ? sc_r + 1 : sc_r;
            fc_r <= !fan_locked ? 0 : (fc_r < 5000) ? fc_r + 1 : fc_r;
            if (cmd_adjust && !busy && ok)
                tgt_r <= (cmd_size > 3'h4) ? 3'h0 : cmd_size;
        end
    end
    fwd_cmd_start_a: assert property (
        cmd_fwd && !cmd_rev && !busy && !reverse_motor_run && ok |=> reverse_motor_run && !reverse_motor_dir)
        else $error("forward command left reverse motor idle");
    rev_cmd_start_a: assert property (
        cmd_rev && !busy && ok |=> rv && busy) else $error("reverse command not obeyed");
    repick_cmd_start_a: assert property (
        cmd_repick && !cmd_rev && !busy && ok |=> repick_motor_run && !repick_motor_dir)
        else $error("repick command not obeyed");
    adjust_cmd_start_a: assert property (
        cmd_adjust && !cmd_rev && !cmd_repick && !busy && ok |=> repick_motor_run && repick_motor_dir)
        else $error("adjust did not reverse repick motor");
    repick_after_rev_a: assert property ($rose(rv) |-> ##[P0:P1] (repick_motor_run || hlt))
        else $error("repick motor late after reversal");
    rev_run_stop_a: assert property ($rose(rv) |-> ##[S0:S1] !reverse_motor_run)
        else $error("reverse motor not stopped in time");
    jam_halts_motors_a: assert property ($rose(hlt) |-> ##[0:1] !(reverse_motor_run || repick_motor_run))
        else $error("motors still running after fault");
    rev_jam_window_a: assert property (
        $rose(jam_reverse_delay) |-> rc_r >= REV_JAM_CYC && rc_r <= REV_JAM_CYC + 3)
        else $error("reverse delay jam at wrong time");
    stat_jam_window_a: assert property (
        $rose(jam_stationary) |-> sc_r >= STAT_JAM_CYC && sc_r <= STAT_JAM_CYC + 3)
        else $error("stationary jam at wrong time");
    fan_lock_time_a: assert property (
        $rose(fan_fail) |-> fc_r >= FAN_LOCK_CYC && fc_r <= FAN_LOCK_CYC + 8)
        else $error("fan failure at wrong time");
    guide_cycle_order_a: assert property (
        !$stable(guide_pos) |-> guide_pos <= 3'h4 && (guide_pos == 3'h0 || guide_pos == $past(guide_pos) + 3'h1))
        else $error("guide position out of order");
    adjust_target_a: assert property (
        $fell(repick_motor_run) && $past(repick_motor_dir) && !guide_fail |-> guide_pos == tgt_r)
        else $error("adjust stopped away from target");
    cover property ($rose(jam_reverse_delay));
    cover property ($rose(guide_fail));
    cover property ($fell(repick_motor_run) && guide_pos == 3'h4);
endmodule
bind dus_sequencer dus_sequencer_chk #(.FAN_LOCK_CYC(FAN_LOCK_CYC), .REV_TO_REPICK_CYC(REV_TO_REPICK_CYC),
    .REV_RUN_CYC(REV_RUN_CYC), .REV_JAM_CYC(REV_JAM_CYC), .STAT_JAM_CYC(STAT_JAM_CYC)) dus_sequencer_chk_i (.*);

// ### sim/dus_sequencer_tb.sv
`timescale 1ns/1ns
module dus_sequencer_tb;
    localparam int TR = 5, RR = 12, LS = 4, TS = 4, RJ = 40, SJ = 40, CT = 10, GS = 8, FL = 20, LD = 6;
    logic clk = 1'b0, rst = 1'b1, delivery = 1'b0, req_repick = 1'b0, req_adjust = 1'b0, cmd_clear = 1'b0;
    logic fan_locked = 1'b0, media = 1'b0, home = 1'b0, face_up = 1'b0;
    logic [2:0] req_size = 3'h0, s;
    wire cmd_fwd, cmd_rev, cmd_repick, cmd_adjust, simplex, cooling_fan_on, reverse_motor_run, reverse_motor_dir;
    wire repick_motor_run, repick_motor_dir, fan_fail, guide_fail, jam_reverse_delay, jam_stationary, busy;
    wire face_up_open;
    wire [2:0] cmd_size, guide_pos;
    int failures = 0, compares = 0, cyc = 0, t0, e;
    int q[$];
    wire [8:0] mon = {fan_fail, guide_fail, jam_stationary, jam_reverse_delay, busy, repick_motor_dir,
        repick_motor_run, reverse_motor_dir, reverse_motor_run};
    always #5 clk = ~clk;
    always @(posedge clk) cyc++;
    dus_sequencer #(.FAN_LOCK_CYC(FL), .REV_TO_REPICK_CYC(TR), .REV_RUN_CYC(RR), .LEAD_STOP_CYC(LS),
        .TRAIL_STOP_CYC(TS), .REV_JAM_CYC(RJ), .STAT_JAM_CYC(SJ), .CAM_TURN_CYC(CT), .GUIDE_STEP_CYC(GS)) dus_sequencer_i (
        .clk(clk), .rst(rst), .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev), .cmd_repick(cmd_repick), .cmd_adjust(cmd_adjust),
        .cmd_size(cmd_size), .cmd_clear(cmd_clear), .fan_locked(fan_locked), .repick_media_sensor(media),
        .guide_home_sensor(home), .face_up_sensor(face_up), .cooling_fan_on(cooling_fan_on),
        .reverse_motor_run(reverse_motor_run), .reverse_motor_dir(reverse_motor_dir),
        .repick_motor_run(repick_motor_run), .repick_motor_dir(repick_motor_dir), .fan_fail(fan_fail),
        .guide_fail(guide_fail), .jam_reverse_delay(jam_reverse_delay), .jam_stationary(jam_stationary),
        .busy(busy), .face_up_open(face_up_open), .guide_pos(guide_pos));
    dus_ctrl_model #(.LEAD_DLY(LD), .TRAIL_DLY(LD)) dus_ctrl_model_i (.clk(clk), .rst(rst), .delivery_sensor(delivery),
        .req_repick(req_repick), .req_adjust(req_adjust), .req_size(req_size),
        .fault(jam_reverse_delay | jam_stationary | guide_fail | fan_fail), .clr(cmd_clear), .cmd_fwd(cmd_fwd),
        .cmd_rev(cmd_rev), .cmd_repick(cmd_repick), .cmd_adjust(cmd_adjust), .cmd_size(cmd_size), .simplex(simplex));
    task automatic chk(input string n, input logic [8:0] x, input logic [8:0] g);
        compares++;
        if (g !== x) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", n, x, g);
        end
    endtask
    // elapsed cycles must fall in a window; sensor filtering makes exact figures unknowable
    task automatic chk_rng(input string n, input int lo, input int hi);
        compares++;
        if (cyc - t0 < lo || cyc - t0 > hi) begin
            failures++;
            $display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, cyc - t0);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait so a stuck output cannot hang the run
    task automatic wt(input int b, input logic v);
        int n;
        n = 0;
        while (mon[b] !== v && n < 300) begin
            tick(1);
            n++;
        end
    endtask
    task automatic clear;
        cmd_clear = 1'b1;
        tick(1);
        cmd_clear = 1'b0;
        tick(2);
    endtask
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        test_done();
    end
    initial begin
        void'($urandom(32'h9E34F7F2));
        tick(2);
        rst = 1'b0;
        chk("idle", 9'h000, mon);
        tick(1);
        chk("fan on", 9'h001, 9'(cooling_fan_on));
        // full reverse and re-pickup of one sheet
        delivery = 1'b1;
        t0 = cyc;
        wt(0, 1'b1);
        chk_rng("fwd lag", LD, LD + 2);
        chk("fwd dir", 9'h000, 9'(reverse_motor_dir));
        tick(3);
        delivery = 1'b0;
        wt(1, 1'b1);
        t0 = cyc;
        chk("rev run", 9'h013, mon[4:0]);
        wt(2, 1'b1);
        chk_rng("repick lag", TR - 1, TR + 1);
        chk("repick fwd", 9'h000, 9'(repick_motor_dir));
        wt(0, 1'b0);
        chk_rng("rev stop", RR - 1, RR + 1);
        media = 1'b1;
        t0 = cyc;
        wt(2, 1'b0);
        chk_rng("lead stop", LS, LS + 7);
        req_repick = 1'b1;
        tick(1);
        req_repick = 1'b0;
        // stopped reverse motor keeps its last (reverse) direction
        chk("repick on", 9'h006, mon[3:0]);
        media = 1'b0;
        t0 = cyc;
        wt(2, 1'b0);
        chk_rng("trail stop", TS, TS + 7);
        chk("busy", 9'h000, 9'(busy));
        // every guide size, plus an out-of-range code, with random home delay
        q = {0, 1, 2, 3, 4};
        q.push_back(5 + $urandom % 3);
        foreach (q[i]) begin
            s = q[i][2:0];
            e = q[i] > 4 ? 0 : q[i];
            req_size = s;
            req_adjust = 1'b1;
            tick(1);
            req_adjust = 1'b0;
            chk("adjust rev", 9'h00C, mon[3:0] & 9'h00C);
            tick($urandom % 4 + 1);
            home = 1'b1;
            t0 = cyc;
            tick(4);
            home = 1'b0;
            wt(2, 1'b0);
            chk("guide pos", 9'(e), 9'(guide_pos));
            chk_rng("step time", e * GS, e * GS + 9);
            // filtered home level lags the pin; a stale high would skip the next home search
            tick(3);
        end
        req_adjust = 1'b1;
        tick(1);
        req_adjust = 1'b0;
        t0 = cyc;
        wt(7, 1'b1);
        chk_rng("guide fail", 2 * CT - 1, 2 * CT + 3);
        chk("halt g", 9'h000, mon[3:0] & 9'h005);
        tick(1);
        chk("simplex", 9'h001, 9'(simplex));
        clear();
        chk("cleared", 9'h000, mon & 9'h1F5);
        // no media ever reaches the re-pickup sensor
        delivery = 1'b1;
        tick(LD + 3);
        delivery = 1'b0;
        wt(1, 1'b1);
        t0 = cyc;
        wt(5, 1'b1);
        chk_rng("rev jam", RJ - 1, RJ + 3);
        // motors drop one edge after the jam flag rises
        tick(1);
        chk("halt r", 9'h000, mon[3:0] & 9'h005);
        clear();
        media = 1'b1;
        tick(6);
        req_repick = 1'b1;
        tick(1);
        req_repick = 1'b0;
        t0 = cyc;
        wt(6, 1'b1);
        chk_rng("stat jam", SJ - 1, SJ + 3);
        tick(1);
        chk("halt s", 9'h000, 9'(repick_motor_run));
        media = 1'b0;
        clear();
        fan_locked = 1'b1;
        face_up = 1'b1;
        t0 = cyc;
        wt(8, 1'b1);
        chk_rng("fan fail", FL, FL + 8);
        chk("face up", 9'h001, 9'(face_up_open));
        test_done();
    end
endmodule
